// File: tb/pmdb_bank_bench.sv
module pmdb_bank_bench
   import pmdb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = 16'h0000;
   logic [ADDR_W-1:0] araddr = 16'h0000;
   logic [DATA_W-1:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pin_change_irq_off, num_ctrl_osc_off, dac_off, adc_off;
   logic [1:0] bresp, rresp;
   logic [DATA_W-1:0] rdata;
   logic comparator_two_off, comparator_one_off, zero_cross_off, pwm_unit_seven_off, pwm_unit_six_off;
   logic capture_unit_four_off, capture_unit_three_off, capture_unit_two_off, capture_unit_one_off;
   logic waveform_gen_two_off, waveform_gen_one_off, async_serial_off, sync_serial_two_off;
   logic sync_serial_one_off, signal_measure_timer_off, signal_modulator_off;
   logic [6:0] timer_n_off;
   logic [3:0] logic_cell_n_off;
   int n_errors = 0;
   int n_tests = 0;
   localparam logic [7:0] MASK [8] = '{8'h01, 8'h7f, 8'h80, 8'h67, 8'h6f, 8'h60, 8'h13, 8'h3f};
   logic [7:0] shadow [8];

   pmdb_bank u_dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .pin_change_irq_off, .timer_n_off, .num_ctrl_osc_off, .dac_off, .adc_off, .comparator_two_off,
      .comparator_one_off, .zero_cross_off, .pwm_unit_seven_off, .pwm_unit_six_off, .capture_unit_four_off,
      .capture_unit_three_off, .capture_unit_two_off, .capture_unit_one_off, .waveform_gen_two_off,
      .waveform_gen_one_off, .async_serial_off, .sync_serial_two_off, .sync_serial_one_off,
      .signal_measure_timer_off, .logic_cell_n_off, .signal_modulator_off);

   // 50 mhz system clock
   always #10 aclk = ~aclk;

   task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // disable outputs regrouped into the bit layout of each register
   function automatic logic [7:0] out_of(input int s);
      case (s)
         0: out_of = {7'h00, pin_change_irq_off};
         1: out_of = {1'b0, timer_n_off};
         2: out_of = {num_ctrl_osc_off, 7'h00};
         3: out_of = {1'b0, dac_off, adc_off, 2'h0, comparator_two_off, comparator_one_off, zero_cross_off};
         4: out_of = {1'b0, pwm_unit_seven_off, pwm_unit_six_off, 1'b0, capture_unit_four_off,
            capture_unit_three_off, capture_unit_two_off, capture_unit_one_off};
         5: out_of = {1'b0, waveform_gen_two_off, waveform_gen_one_off, 5'h00};
         6: out_of = {3'h0, async_serial_off, 2'h0, sync_serial_two_off, sync_serial_one_off};
         default: out_of = {2'h0, signal_measure_timer_off, logic_cell_n_off, signal_modulator_off};
      endcase
   endfunction

   // one write, address and data offered together; i counts registers from the pin change one
   task automatic wr(input int i, input logic [7:0] d, input logic [3:0] s, output logic [1:0] resp);
      logic a_ok;
      logic w_ok;
      a_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= {IDX_PIN_CHANGE + 14'(i), 2'h0};
      awvalid <= 1'b1;
      wdata <= {24'hc3c3c3, d};  // upper bits must be ignored
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a_ok && w_ok)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            a_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input int i, output logic [31:0] d, output logic [1:0] resp);
      @(posedge aclk);
      araddr <= {IDX_PIN_CHANGE + 14'(i), 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      while ((arvalid && arready) !== 1'b1) @(posedge aclk);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // write and track what the register should now hold
   task automatic put(input int i, input logic [7:0] d, input logic [3:0] s, input logic [1:0] exp);
      logic [1:0] resp;
      wr(i, d, s, resp);
      check(resp, exp, "write response");
      if (s[0] && exp === RESP_OKAY)
         shadow[i] = d & MASK[i];
   endtask

   // every output and every read-back against the tracked contents
   task automatic chk_all();
      logic [31:0] d;
      logic [1:0] r;
      repeat (2) @(posedge aclk);
      #1;
      for (int j = 0; j < 8; j++) begin
         check(out_of(j), shadow[j], "outputs");
         rd(j, d, r);
         check({r, d}, {RESP_OKAY, 24'h000000, shadow[j]}, "read back");
      end
   endtask

   task automatic test_reset_values();
      foreach (shadow[j]) shadow[j] = 8'h00;
      chk_all();
      $display("test reset_values done, mismatches %0d", n_errors);
   endtask

   // one bit at a time also exposes swapped fields and crosstalk
   task automatic test_bit_walk();
      for (int i = 0; i < 8; i++) begin
         for (int b = 0; b < 8; b++) begin
            put(i, 8'h01 << b, 4'h1, RESP_OKAY);
            chk_all();
         end
         put(i, 8'h00, 4'h1, RESP_OKAY);
         repeat (50) @(posedge aclk); // software settles 1 us after re-enabling before any access
      end
      $display("test bit_walk done, mismatches %0d", n_errors);
   endtask

   task automatic test_ignored_writes();
      logic [31:0] d;
      logic [1:0] r;
      put(1, 8'h55, 4'h1, RESP_OKAY);
      put(1, 8'haa, 4'h0, RESP_OKAY);
      put(2, 8'hff, 4'he, RESP_OKAY);
      put(-1, 8'hff, 4'h1, RESP_SLVERR);
      put(8, 8'hff, 4'h1, RESP_SLVERR);
      rd(-1, d, r);
      check({r, d}, {RESP_SLVERR, 32'h00000000}, "unmapped read low");
      rd(8, d, r);
      check({r, d}, {RESP_SLVERR, 32'h00000000}, "unmapped read high");
      chk_all();
      $display("test ignored_writes done, mismatches %0d", n_errors);
   endtask

   task automatic test_mid_reset();
      for (int i = 0; i < 8; i++) put(i, 8'hff, 4'h1, RESP_OKAY);
      chk_all();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (shadow[j]) shadow[j] = 8'h00;
      chk_all();
      $display("test mid_reset done, mismatches %0d", n_errors);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // main sequence after 8 cycles of reset
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      test_reset_values();
      test_bit_walk();
      test_ignored_writes();
      test_mid_reset();
      print_verdict();
   end

   // the whole run needs well under 10000 cycles
   initial begin
      repeat (40000) @(posedge aclk);
      n_errors++;
      $display("unexpected at %0t ns: watchdog expired", $time);
      print_verdict();
   end
endmodule

// File: tb/pmdb_bank_monitor.sv
module pmdb_bank_monitor
   import pmdb_pkg::*;
(
   input wire logic aclk,                 // clock
   input wire logic aresetn,              // sync reset
   input wire logic [ADDR_W-1:0] awaddr,  // write address
   input wire logic awvalid,              // aw valid
   input wire logic awready,              // aw ready
   input wire logic [DATA_W-1:0] wdata,   // write data
   input wire logic [3:0] wstrb,          // strobes
   input wire logic wvalid,               // w valid
   input wire logic wready,               // w ready
   input wire logic [1:0] bresp,          // write response
   input wire logic bvalid,               // b valid
   input wire logic arvalid,              // ar valid
   input wire logic arready,              // ar ready
   input wire logic [DATA_W-1:0] rdata,   // read data
   input wire logic rvalid,               // r valid
   input wire logic pin_change_irq_off,   // change irq off
   input wire logic [6:0] timer_n_off,    // timers off
   input wire logic num_ctrl_osc_off      // oscillator off
);
   timeunit 1ns;
   timeprecision 1ps;

   // last write address and data, held until the response is out
   logic [ADDR_W-1:0] wa_r;
   logic [7:0] wd_r;
   logic ws_r;
   always_ff @(posedge aclk) begin
      if (awvalid && awready)
         wa_r <= awaddr;
      if (wvalid && wready) begin
         wd_r <= wdata[7:0];
         ws_r <= wstrb[0];
      end
   end

   // decoded view of the pending write
   logic [IDX_W-1:0] wa_idx;
   logic wr_ok;
   assign wa_idx = wa_r[ADDR_W-1:2];
   assign wr_ok = (bresp == RESP_OKAY) && ws_r;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_reset_clear: assert property ($rose(aresetn) |->
      !pin_change_irq_off && timer_n_off == 7'h00 && !num_ctrl_osc_off) else $error("outputs set after reset");
   chk_timer_write: assert property ($rose(bvalid) && wr_ok && wa_idx == IDX_TIMER |->
      ##1 timer_n_off == wd_r[6:0]) else $error("timer disables differ from written data");
   chk_osc_write: assert property ($rose(bvalid) && wr_ok && wa_idx == IDX_OSC |->
      ##1 num_ctrl_osc_off == wd_r[7]) else $error("oscillator disable differs from bit 7");
   chk_pin_write: assert property ($rose(bvalid) && wr_ok && wa_idx == IDX_PIN_CHANGE |->
      ##1 pin_change_irq_off == wd_r[0]) else $error("pin change disable differs from bit 0");
   chk_ignored_keep: assert property ($rose(bvalid) && !wr_ok |->
      ##1 $stable(timer_n_off) && $stable(num_ctrl_osc_off)) else $error("ignored write changed outputs");
   chk_unmapped_err: assert property ($rose(bvalid) |->
      (bresp == RESP_SLVERR) == (wa_idx < IDX_PIN_CHANGE || wa_idx > IDX_LOGIC_MEAS)) else $error("wrong bresp");
   chk_timer_cause: assert property ($changed(timer_n_off) |-> $past(bvalid))
      else $error("timer disables changed without a write");
   chk_read_latency: assert property (arvalid && arready |-> ##2 rvalid)
      else $error("read answer late");
   chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
      else $error("read data upper bits set");

   // main scenarios seen
   cov_write_ok: cover property ($rose(bvalid) && bresp == RESP_OKAY);
   cov_write_err: cover property ($rose(bvalid) && bresp == RESP_SLVERR);
   cov_read: cover property ($rose(rvalid));
endmodule

bind pmdb_bank pmdb_bank_monitor u_mon (
   .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
   .arvalid, .arready, .rdata, .rvalid, .pin_change_irq_off, .timer_n_off, .num_ctrl_osc_off
);

// File: verilog/pmdb_bank.sv
// Functional notes
// - pin-change disable bit set turns off change interrupts on all ports.
// - register at 0x797 bits 0..6 disable timers 0..6.
// - register at 0x798 bit 7 disables the numeric oscillator.
// - 0x799: dac bit 6, adc 5, comparators 2 and 1, zero cross 0.
// - 0x79A: pwm 7 bit 6, pwm 6 bit 5, capture units 4..1 bits 3..0.
// - 0x79B: waveform generator 2 bit 6, generator 1 bit 5.
// - 0x79C: async serial bit 4, sync serial 2 bit 1, 1 bit 0.
// - 0x79D: measure timer bit 5, logic cells 4..1 bits 4..1, modulator 0.
module pmdb_bank
   import pmdb_pkg::*;
(
   input wire logic aclk,                  // system clock
   input wire logic aresetn,               // sync reset, active low
   input wire logic [ADDR_W-1:0] awaddr,   // write address
   input wire logic [2:0] awprot,          // write protection, unused
   input wire logic awvalid,               // write address valid
   output logic awready,                   // write address ready
   input wire logic [DATA_W-1:0] wdata,    // write data
   input wire logic [3:0] wstrb,           // write byte strobes
   input wire logic wvalid,                // write data valid
   output logic wready,                    // write data ready
   output logic [1:0] bresp,               // write response
   output logic bvalid,                    // write response valid
   input wire logic bready,                // write response ready
   input wire logic [ADDR_W-1:0] araddr,   // read address
   input wire logic [2:0] arprot,          // read protection, unused
   input wire logic arvalid,               // read address valid
   output logic arready,                   // read address ready
   output logic [DATA_W-1:0] rdata,        // read data
   output logic [1:0] rresp,               // read response
   output logic rvalid,                    // read data valid
   input wire logic rready,                // read data ready
   output logic pin_change_irq_off,        // all ports change irq off
   output logic [6:0] timer_n_off,         // timers 6..0 off
   output logic num_ctrl_osc_off,          // numeric oscillator off
   output logic dac_off,                   // dac off
   output logic adc_off,                   // adc off
   output logic comparator_two_off,        // comparator 2 off
   output logic comparator_one_off,        // comparator 1 off
   output logic zero_cross_off,            // zero cross detector off
   output logic pwm_unit_seven_off,        // pwm 7 off
   output logic pwm_unit_six_off,          // pwm 6 off
   output logic capture_unit_four_off,     // capture unit 4 off
   output logic capture_unit_three_off,    // capture unit 3 off
   output logic capture_unit_two_off,      // capture unit 2 off
   output logic capture_unit_one_off,      // capture unit 1 off
   output logic waveform_gen_two_off,      // waveform gen 2 off
   output logic waveform_gen_one_off,      // waveform gen 1 off
   output logic async_serial_off,          // async serial port off
   output logic sync_serial_two_off,       // sync serial 2 off
   output logic sync_serial_one_off,       // sync serial 1 off
   output logic signal_measure_timer_off,  // measure timer off
   output logic [3:0] logic_cell_n_off,    // logic cells 4..1 off
   output logic signal_modulator_off       // signal modulator off
);

   // index to slot; the same map serves writes and reads
   function automatic logic [SLOT_W:0] idx_decode(input logic [ADDR_W-1:0] addr);
      logic [IDX_W-1:0] idx;
      logic [SLOT_W:0] res;
      idx = addr[ADDR_W-1:2];
      res = '0;
      unique case (idx)
         IDX_PIN_CHANGE: res = {1'b1, SL_PIN_CHANGE};
         IDX_TIMER: res = {1'b1, SL_TIMER};
         IDX_OSC: res = {1'b1, SL_OSC};
         IDX_ANALOG: res = {1'b1, SL_ANALOG};
         IDX_PWM_CAP: res = {1'b1, SL_PWM_CAP};
         IDX_WAVE_GEN: res = {1'b1, SL_WAVE_GEN};
         IDX_SERIAL: res = {1'b1, SL_SERIAL};
         IDX_LOGIC_MEAS: res = {1'b1, SL_LOGIC_MEAS};
         default: res = '0;
      endcase
      return res;
   endfunction

   // write channel state
   pmdb_wr_st_t wr_st_r, wr_st_nxt;
   logic aw_got_r, aw_got_nxt;
   logic w_got_r, w_got_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [REG_W-1:0] wbyte_r, wbyte_nxt;
   logic wlane_r, wlane_nxt;
   logic awready_r, awready_nxt;
   logic wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;

   // read channel state
   pmdb_rd_st_t rd_st_r, rd_st_nxt;
   logic arready_r, arready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic rhit_r, rhit_nxt;

   // register file hookup
   logic rf_wr_en;
   logic [SLOT_W-1:0] rf_wr_slot;
   logic [REG_W-1:0] rf_wr_data;
   logic rf_rd_en;
   logic [SLOT_W-1:0] rf_rd_slot;
   logic [REG_W-1:0] rf_rd_data;
   logic [SLOTS*REG_W-1:0] rf_all;

   // helpers
   logic aw_hs, w_hs, ar_hs;
   logic [ADDR_W-1:0] wr_addr;
   logic [REG_W-1:0] wr_byte;
   logic wr_lane;
   logic [SLOT_W:0] wr_dec, rd_dec;

   // disable outputs, one flop per slot bit
   logic [SLOTS*REG_W-1:0] off_r, off_nxt;

   assign aw_hs = awvalid & awready_r;
   assign w_hs = wvalid & wready_r;
   assign ar_hs = arvalid & arready_r;

   // address and data arrive in either order; use the live one if just taken
   assign wr_addr = aw_got_r ? awaddr_r : awaddr;
   assign wr_byte = w_got_r ? wbyte_r : wdata[REG_W-1:0];
   assign wr_lane = w_got_r ? wlane_r : wstrb[0];
   assign wr_dec = idx_decode(wr_addr);
   assign rd_dec = idx_decode(araddr);

   // write channel next state
   always_comb begin
      wr_st_nxt = wr_st_r;
      aw_got_nxt = aw_got_r;
      w_got_nxt = w_got_r;
      awaddr_nxt = awaddr_r;
      wbyte_nxt = wbyte_r;
      wlane_nxt = wlane_r;
      awready_nxt = awready_r;
      wready_nxt = wready_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rf_wr_en = 1'b0;
      rf_wr_slot = wr_dec[SLOT_W-1:0];
      rf_wr_data = wr_byte;
      unique case (wr_st_r)
         WR_IDLE: begin
            if (aw_hs) begin
               aw_got_nxt = 1'b1;
               awaddr_nxt = awaddr;
            end
            if (w_hs) begin
               w_got_nxt = 1'b1;
               wbyte_nxt = wdata[REG_W-1:0];
               wlane_nxt = wstrb[0];
            end
            if ((aw_got_r | aw_hs) && (w_got_r | w_hs)) begin
               // only lane 0 carries data; others are zero-filled bits
               rf_wr_en = wr_dec[SLOT_W] & wr_lane;
               bresp_nxt = wr_dec[SLOT_W] ? RESP_OKAY : RESP_SLVERR;
               bvalid_nxt = 1'b1;
               aw_got_nxt = 1'b0;
               w_got_nxt = 1'b0;
               awready_nxt = 1'b0;
               wready_nxt = 1'b0;
               wr_st_nxt = WR_RESP;
            end else begin
               awready_nxt = ~aw_got_nxt;
               wready_nxt = ~w_got_nxt;
            end
         end
         WR_RESP: begin
            if (bready) begin
               bvalid_nxt = 1'b0;
               awready_nxt = 1'b1;
               wready_nxt = 1'b1;
               wr_st_nxt = WR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_st_r <= WR_IDLE;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= '0;
         wbyte_r <= '0;
         wlane_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         wr_st_r <= wr_st_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awaddr_r <= awaddr_nxt;
         wbyte_r <= wbyte_nxt;
         wlane_r <= wlane_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   // read channel next state; one wait cycle for the registered file
   always_comb begin
      rd_st_nxt = rd_st_r;
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      rhit_nxt = rhit_r;
      rf_rd_en = 1'b0;
      rf_rd_slot = rd_dec[SLOT_W-1:0];
      unique case (rd_st_r)
         RD_IDLE: begin
            arready_nxt = 1'b1;
            if (ar_hs) begin
               rf_rd_en = rd_dec[SLOT_W];
               rhit_nxt = rd_dec[SLOT_W];
               arready_nxt = 1'b0;
               rd_st_nxt = RD_WAIT;
            end
         end
         RD_WAIT: begin
            // upper bits and misses read as zero
            rdata_nxt = rhit_r ? {{(DATA_W-REG_W){1'b0}}, rf_rd_data} : '0;
            rresp_nxt = rhit_r ? RESP_OKAY : RESP_SLVERR;
            rvalid_nxt = 1'b1;
            rd_st_nxt = RD_RESP;
         end
         RD_RESP: begin
            if (rready) begin
               rvalid_nxt = 1'b0;
               arready_nxt = 1'b1;
               rd_st_nxt = RD_IDLE;
            end
         end
         default: begin
            rd_st_nxt = RD_IDLE;
            rvalid_nxt = 1'b0;
            arready_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_st_r <= RD_IDLE;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
         rhit_r <= 1'b0;
      end else begin
         rd_st_r <= rd_st_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         rhit_r <= rhit_nxt;
      end
   end

   pmdb_regfile u_regs (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(rf_wr_en),
      .wr_slot(rf_wr_slot),
      .wr_data(rf_wr_data),
      .rd_en(rf_rd_en),
      .rd_slot(rf_rd_slot),
      .rd_data(rf_rd_data),
      .all_regs(rf_all)
   );

   // outputs follow the stored bits one cycle later, glitch-free fan-out
   always_comb begin
      off_nxt = rf_all;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         off_r <= '0; // all modules enabled out of reset
      end else begin
         off_r <= off_nxt;
      end
   end

   // slot byte helpers for the fan-out below
   logic [REG_W-1:0] o_pin, o_tmr, o_osc, o_ana, o_pwm, o_wg, o_ser, o_lm;
   assign o_pin = off_r[SL_PIN_CHANGE*REG_W +: REG_W];
   assign o_tmr = off_r[SL_TIMER*REG_W +: REG_W];
   assign o_osc = off_r[SL_OSC*REG_W +: REG_W];
   assign o_ana = off_r[SL_ANALOG*REG_W +: REG_W];
   assign o_pwm = off_r[SL_PWM_CAP*REG_W +: REG_W];
   assign o_wg = off_r[SL_WAVE_GEN*REG_W +: REG_W];
   assign o_ser = off_r[SL_SERIAL*REG_W +: REG_W];
   assign o_lm = off_r[SL_LOGIC_MEAS*REG_W +: REG_W];

   // per-peripheral disables, 1 = off, 0 = on
   assign pin_change_irq_off = o_pin[B_PIN_CHANGE];
   assign timer_n_off = o_tmr[B_TIMER_LO +: 7];
   assign num_ctrl_osc_off = o_osc[B_OSC];
   assign dac_off = o_ana[B_DAC];
   assign adc_off = o_ana[B_ADC];
   assign comparator_two_off = o_ana[B_CMP2];
   assign comparator_one_off = o_ana[B_CMP1];
   assign zero_cross_off = o_ana[B_ZCD];
   assign pwm_unit_seven_off = o_pwm[B_PWM7];
   assign pwm_unit_six_off = o_pwm[B_PWM6];
   assign capture_unit_four_off = o_pwm[B_CAP4];
   assign capture_unit_three_off = o_pwm[B_CAP3];
   assign capture_unit_two_off = o_pwm[B_CAP2];
   assign capture_unit_one_off = o_pwm[B_CAP1];
   assign waveform_gen_two_off = o_wg[B_WG2];
   assign waveform_gen_one_off = o_wg[B_WG1];
   assign async_serial_off = o_ser[B_ASYNC];
   assign sync_serial_two_off = o_ser[B_SYNC2];
   assign sync_serial_one_off = o_ser[B_SYNC1];
   assign signal_measure_timer_off = o_lm[B_SMT];
   assign logic_cell_n_off = o_lm[B_CELL_LO +: 4];
   assign signal_modulator_off = o_lm[B_DSM];

   // bus outputs straight from their flops
   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

endmodule

// File: verilog/pmdb_pkg.sv
package pmdb_pkg;

   // bus geometry
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int IDX_W = 14;
   localparam int SLOT_W = 3;
   localparam int SLOTS = 8;
   localparam int REG_W = 8;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_PIN_CHANGE = 14'h0796;
   localparam logic [IDX_W-1:0] IDX_TIMER = 14'h0797;
   localparam logic [IDX_W-1:0] IDX_OSC = 14'h0798;
   localparam logic [IDX_W-1:0] IDX_ANALOG = 14'h0799;
   localparam logic [IDX_W-1:0] IDX_PWM_CAP = 14'h079a;
   localparam logic [IDX_W-1:0] IDX_WAVE_GEN = 14'h079b;
   localparam logic [IDX_W-1:0] IDX_SERIAL = 14'h079c;
   localparam logic [IDX_W-1:0] IDX_LOGIC_MEAS = 14'h079d;

   // storage slots, in index order
   localparam logic [SLOT_W-1:0] SL_PIN_CHANGE = 3'h0;
   localparam logic [SLOT_W-1:0] SL_TIMER = 3'h1;
   localparam logic [SLOT_W-1:0] SL_OSC = 3'h2;
   localparam logic [SLOT_W-1:0] SL_ANALOG = 3'h3;
   localparam logic [SLOT_W-1:0] SL_PWM_CAP = 3'h4;
   localparam logic [SLOT_W-1:0] SL_WAVE_GEN = 3'h5;
   localparam logic [SLOT_W-1:0] SL_SERIAL = 3'h6;
   localparam logic [SLOT_W-1:0] SL_LOGIC_MEAS = 3'h7;

   // implemented bits per slot
   localparam logic [SLOTS*REG_W-1:0] IMPL_MASKS = {
      8'h3f,  // logic cells, modulator, measure timer
      8'h13,  // serial ports
      8'h60,  // waveform generators
      8'h6f,  // pwm and capture units
      8'h67,  // dac, adc, comparators, zero cross
      8'h80,  // oscillator
      8'h7f,  // timers 0..6
      8'h01   // pin-change interrupt
   };
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;

   // field positions
   localparam int B_PIN_CHANGE = 0;
   localparam int B_TIMER_LO = 0;
   localparam int B_OSC = 7;
   localparam int B_DAC = 6;
   localparam int B_ADC = 5;
   localparam int B_CMP2 = 2;
   localparam int B_CMP1 = 1;
   localparam int B_ZCD = 0;
   localparam int B_PWM7 = 6;
   localparam int B_PWM6 = 5;
   localparam int B_CAP4 = 3;
   localparam int B_CAP3 = 2;
   localparam int B_CAP2 = 1;
   localparam int B_CAP1 = 0;
   localparam int B_WG2 = 6;
   localparam int B_WG1 = 5;
   localparam int B_ASYNC = 4;
   localparam int B_SYNC2 = 1;
   localparam int B_SYNC1 = 0;
   localparam int B_SMT = 5;
   localparam int B_CELL_LO = 1;
   localparam int B_DSM = 0;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {WR_IDLE, WR_RESP} pmdb_wr_st_t;
   typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} pmdb_rd_st_t;

endpackage

// File: verilog/pmdb_regfile.sv
module pmdb_regfile
   import pmdb_pkg::*;
(
   input wire logic aclk,                      // system clock
   input wire logic aresetn,                   // sync reset, active low
   input wire logic wr_en,                     // write one slot
   input wire logic [SLOT_W-1:0] wr_slot,      // slot written
   input wire logic [REG_W-1:0] wr_data,       // data written
   input wire logic rd_en,                     // read one slot
   input wire logic [SLOT_W-1:0] rd_slot,      // slot read
   output logic [REG_W-1:0] rd_data,           // registered read data
   output logic [SLOTS*REG_W-1:0] all_regs     // every slot, flat
);

   logic [REG_W-1:0] mem_r [SLOTS];
   logic [REG_W-1:0] mem_nxt [SLOTS];
   logic [REG_W-1:0] rd_data_r;
   logic [REG_W-1:0] rd_data_nxt;

   // per-slot update; unimplemented bits stay zero
   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_slot
         always_comb begin
            mem_nxt[g] = mem_r[g];
            if (wr_en && wr_slot == SLOT_W'(g)) begin
               mem_nxt[g] = wr_data & IMPL_MASKS[g*REG_W +: REG_W];
            end
         end
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               mem_r[g] <= REG_RESET;
            end else begin
               mem_r[g] <= mem_nxt[g];
            end
         end
         assign all_regs[g*REG_W +: REG_W] = mem_r[g];
      end
   endgenerate

   // read data held until the next read of a mapped slot
   always_comb begin
      rd_data_nxt = rd_data_r;
      if (rd_en) begin
         rd_data_nxt = mem_r[rd_slot];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_data_r <= REG_RESET;
      end else begin
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data = rd_data_r;

endmodule
